// File: design/ids_defs.svh
// Register offsets, field positions, reset values and width limits of the deserializer
`ifndef IDS_DEFS_SVH
`define IDS_DEFS_SVH
`define IDS_ADDR_W        4
`define IDS_OFF_CTRL      4'h0
`define IDS_OFF_STATUS    4'h4
`define IDS_OFF_STROBE    4'h8
`define IDS_OFF_CONFIG    4'hC
`define IDS_CTRL_SLIP_EN  0
`define IDS_CTRL_RST      1'h0
`define IDS_STAT_WORD_LSB 0
`define IDS_STAT_SLIP_LSB 8
`define IDS_CFG_RATE_LSB  0
`define IDS_CFG_MODEL_LSB 1
`define IDS_CFG_ROLE_LSB  2
`define IDS_CFG_NCE_LSB   4
`define IDS_CFG_WIDTH_LSB 8
`define IDS_RESP_OKAY     2'h0
`define IDS_RESP_SLVERR   2'h2
`define IDS_SDR_W_MIN     2
`define IDS_SDR_W_MAX     8
`define IDS_DDR_W_MIN     4
`define IDS_DDR_W_MAX     10
`define IDS_CELL_W_MAX    6
`define IDS_SLAVE_LSB     2
`endif

// File: design/ids_pkg.sv
// Mode types of the input deserializer
package ids_pkg;
    typedef enum logic {IDS_SDR, IDS_DDR} ids_rate_e;
    typedef enum logic {IDS_MEMORY, IDS_NETWORKING} ids_model_e;
    typedef enum logic {IDS_MASTER, IDS_SLAVE} ids_role_e;
endpackage : ids_pkg

// File: design/ids_axil_regs.sv
// AXI4-Lite register slave of the input deserializer
`timescale 1ns/10ps
`include "ids_defs.svh"
module ids_axil_regs (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [`IDS_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [`IDS_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i,
    input  wire logic [31:0]            status_i,
    input  wire logic [31:0]            strobe_i,
    input  wire logic [31:0]            config_i,
    output logic                        slip_en_o
);
    logic                   aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [`IDS_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0]            wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0]             wstrb_reg, wstrb_next;
    logic                   bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]             bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic                   ctrl_reg, ctrl_next;

    // Sub-word address bits are ignored; offsets are word aligned
    function automatic logic is_mapped(input logic [`IDS_ADDR_W-1:0] a);
        return a[`IDS_ADDR_W-1:2] <= `IDS_OFF_CONFIG >> 2;
    endfunction : is_mapped

    assign s_axi_awready_o = !aw_hold_reg;
    assign s_axi_wready_o  = !w_hold_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign slip_en_o       = ctrl_reg;

    always_comb begin
        aw_hold_next = aw_hold_reg;
        awaddr_next  = awaddr_reg;
        w_hold_next  = w_hold_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        ctrl_next    = ctrl_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axi_awvalid_i && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            awaddr_next  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_hold_reg) begin
            w_hold_next = 1'b1;
            wdata_next  = s_axi_wdata_i;
            wstrb_next  = s_axi_wstrb_i;
        end
        if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        // Write completes once both halves are held and no response is pending
        if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = is_mapped(awaddr_reg) ? `IDS_RESP_OKAY : `IDS_RESP_SLVERR;
            if (awaddr_reg[`IDS_ADDR_W-1:2] == `IDS_OFF_CTRL >> 2 && wstrb_reg[0]) begin
                ctrl_next = wdata_reg[`IDS_CTRL_SLIP_EN];
            end
        end
        // Read data held until rready takes it
        if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid_i && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = is_mapped(s_axi_araddr_i) ? `IDS_RESP_OKAY : `IDS_RESP_SLVERR;
            unique case (s_axi_araddr_i[`IDS_ADDR_W-1:2])
                `IDS_OFF_CTRL >> 2:   rdata_next = {31'h0, ctrl_reg};
                `IDS_OFF_STATUS >> 2: rdata_next = status_i;
                `IDS_OFF_STROBE >> 2: rdata_next = strobe_i;
                `IDS_OFF_CONFIG >> 2: rdata_next = config_i;
                default:              rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            ctrl_reg    <= `IDS_CTRL_RST;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= 2'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            awaddr_reg  <= awaddr_next;
            w_hold_reg  <= w_hold_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            ctrl_reg    <= ctrl_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end
endmodule : ids_axil_regs

// File: design/ids_top.sv
// Input deserializer cell: sampled serial stream to parallel words, cascade and slip
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ids_defs.svh"
module ids_top #(
    parameter ids_pkg::ids_rate_e  RATE_SEL    = ids_pkg::IDS_DDR,
    parameter int                  PAR_W       = 4,
    parameter ids_pkg::ids_model_e USE_MODEL   = ids_pkg::IDS_MEMORY,
    parameter int                  EN_COUNT    = 2,
    parameter ids_pkg::ids_role_e  ROLE        = ids_pkg::IDS_MASTER,
    parameter bit                  HAS_PARTNER = 1'b0
) (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   serial_i,
    input  wire logic                   fast_clock_i,
    input  wire logic                   slow_clock_i,
    input  wire logic                   strobe_clock_i,
    input  wire logic                   clock_enable_a_i,
    input  wire logic                   clock_enable_b_i,
    input  wire logic                   slip_pulse_i,
    input  wire logic [1:0]             cascade_in_i,
    output logic [1:0]                  cascade_out_o,
    output logic [5:0]                  par_out_bit_o,
    input  wire logic [`IDS_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                   s_axi_awvalid_i,
    output logic                        s_axi_awready_o,
    input  wire logic [31:0]            s_axi_wdata_i,
    input  wire logic [3:0]             s_axi_wstrb_i,
    input  wire logic                   s_axi_wvalid_i,
    output logic                        s_axi_wready_o,
    output logic [1:0]                  s_axi_bresp_o,
    output logic                        s_axi_bvalid_o,
    input  wire logic                   s_axi_bready_i,
    input  wire logic [`IDS_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                   s_axi_arvalid_i,
    output logic                        s_axi_arready_o,
    output logic [31:0]                 s_axi_rdata_o,
    output logic [1:0]                  s_axi_rresp_o,
    output logic                        s_axi_rvalid_o,
    input  wire logic                   s_axi_rready_i
);
    localparam bit IS_DDR  = (RATE_SEL == ids_pkg::IDS_DDR);
    localparam bit IS_NET  = (USE_MODEL == ids_pkg::IDS_NETWORKING);
    localparam bit IS_SLV  = (ROLE == ids_pkg::IDS_SLAVE);
    localparam bit CASC    = (PAR_W > `IDS_CELL_W_MAX);
    localparam int CELL_W  = !CASC ? PAR_W : (IS_SLV ? PAR_W - `IDS_CELL_W_MAX : `IDS_CELL_W_MAX);
    localparam int OUT_LSB = (CASC && IS_SLV) ? `IDS_SLAVE_LSB : 0;
    localparam logic [5:0] CELL_MASK = 6'h3F >> (`IDS_CELL_W_MAX - CELL_W);
    localparam bit SDR_OK  = !IS_DDR && PAR_W >= `IDS_SDR_W_MIN && PAR_W <= `IDS_SDR_W_MAX;
    localparam bit DDR_OK  = IS_DDR && PAR_W >= `IDS_DDR_W_MIN && PAR_W <= `IDS_DDR_W_MAX && PAR_W % 2 == 0;
    localparam int SY_FCLK = 0;
    localparam int SY_DAT  = 1;
    localparam int SY_SLOW = 2;
    localparam int SY_STRB = 3;

    // Same width on both cells keeps this check identical in master and slave
    if (!(SDR_OK || DDR_OK)) begin : g_bad_width
        $error("ids_top: width not legal for selected rate");
    end
    if (CASC && !HAS_PARTNER) begin : g_no_partner
        $error("ids_top: width above six needs a cascade partner");
    end
    if (EN_COUNT != 1 && EN_COUNT != 2) begin : g_bad_ce
        $error("ids_top: clock enable count must be one or two");
    end

    logic [3:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
    logic [3:0] agree, rise, fall;
    logic       d_now, shift_en, slow_en, slip_en, slip_ok, slip_step;
    logic [5:0] chain_reg, chain_next, stage_reg, stage_next, par_reg, par_next, raw_word;
    logic [3:0] slip_cnt_reg, slip_cnt_next;
    logic [15:0] strb_cnt_reg, strb_cnt_next;
    int         rot_amt;

    // Rotate left within the cell width; bits above the cell width stay zero
    function automatic logic [5:0] rotl(input logic [5:0] v, input int amt);
        logic [5:0] r;
        r = 6'h0;
        for (int i = 0; i < CELL_W; i++) begin
            r[(i + amt) % CELL_W] = v[i];
        end
        return r;
    endfunction : rotl

    // Pin sampler: a change counts once second and third stages agree
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign rise  = agree & sync3_reg & ~lvl_reg;
    assign fall  = agree & ~sync3_reg & lvl_reg;
    always_comb begin
        lvl_next = (agree & sync3_reg) | (~agree & lvl_reg);
    end
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
            lvl_reg   <= 4'h0;
        end else begin
            sync1_reg <= {strobe_clock_i, slow_clock_i, serial_i, fast_clock_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg   <= lvl_next;
        end
    end

    assign d_now   = agree[SY_DAT] ? sync3_reg[SY_DAT] : lvl_reg[SY_DAT];
    assign slow_en = rise[SY_SLOW];
    // Single rate shifts on rising edges only; double rate on both
    assign shift_en = (rise[SY_FCLK] & clock_enable_a_i)
                    | (IS_DDR & fall[SY_FCLK] & (EN_COUNT == 2 ? clock_enable_b_i : clock_enable_a_i));
    assign slip_ok   = IS_NET & slip_en;
    assign slip_step = slow_en & slip_pulse_i & slip_ok;
    assign raw_word  = chain_reg & CELL_MASK;

    // Double rate slip alternates right one, left three; single rate left one
    always_comb begin
        rot_amt = int'(slip_cnt_reg);
        if (IS_DDR && slip_cnt_reg[0]) begin
            rot_amt = (int'(slip_cnt_reg) + CELL_W - 2) % CELL_W;
        end
        // Bypass: a count left from an earlier enable must not reorder output
        if (!slip_ok) begin
            rot_amt = 0;
        end
    end

    always_comb begin
        // Newest bit enters at bit 0, so the oldest sits highest
        chain_next    = shift_en ? {chain_reg[4:0], (CASC && IS_SLV) ? cascade_in_i[0] : d_now} : chain_reg;
        stage_next    = stage_reg;
        par_next      = par_reg;
        slip_cnt_next = slip_cnt_reg;
        strb_cnt_next = strb_cnt_reg;
        if (slip_step) begin
            slip_cnt_next = (int'(slip_cnt_reg) == CELL_W - 1) ? 4'h0 : slip_cnt_reg + 4'h1;
        end
        if (slow_en) begin
            if (IS_NET) begin
                stage_next = raw_word;
                par_next   = 6'(rotl(stage_reg, rot_amt) << OUT_LSB);
            end else begin
                par_next   = 6'(raw_word << OUT_LSB);
            end
        end
        // Strobe edges only tracked in memory model; unused in networking
        if (!IS_NET && rise[SY_STRB]) begin
            strb_cnt_next = strb_cnt_reg + 16'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            chain_reg    <= 6'h0;
            stage_reg    <= 6'h0;
            par_reg      <= 6'h0;
            slip_cnt_reg <= 4'h0;
            strb_cnt_reg <= 16'h0;
        end else begin
            chain_reg    <= chain_next;
            stage_reg    <= stage_next;
            par_reg      <= par_next;
            slip_cnt_reg <= slip_cnt_next;
            strb_cnt_reg <= strb_cnt_next;
        end
    end

    assign par_out_bit_o = par_reg;
    assign cascade_out_o = chain_reg[5:4];

    ids_axil_regs u_regs (
        .mclk_i          (mclk_i),
        .sys_rst_i       (sys_rst_i),
        .s_axi_awaddr_i  (s_axi_awaddr_i),
        .s_axi_awvalid_i (s_axi_awvalid_i),
        .s_axi_awready_o (s_axi_awready_o),
        .s_axi_wdata_i   (s_axi_wdata_i),
        .s_axi_wstrb_i   (s_axi_wstrb_i),
        .s_axi_wvalid_i  (s_axi_wvalid_i),
        .s_axi_wready_o  (s_axi_wready_o),
        .s_axi_bresp_o   (s_axi_bresp_o),
        .s_axi_bvalid_o  (s_axi_bvalid_o),
        .s_axi_bready_i  (s_axi_bready_i),
        .s_axi_araddr_i  (s_axi_araddr_i),
        .s_axi_arvalid_i (s_axi_arvalid_i),
        .s_axi_arready_o (s_axi_arready_o),
        .s_axi_rdata_o   (s_axi_rdata_o),
        .s_axi_rresp_o   (s_axi_rresp_o),
        .s_axi_rvalid_o  (s_axi_rvalid_o),
        .s_axi_rready_i  (s_axi_rready_i),
        .status_i        ({20'h0, slip_cnt_reg, 2'h0, par_reg}),
        .strobe_i        ({16'h0, strb_cnt_reg}),
        .config_i        ({20'h0, 4'(PAR_W), 4'(EN_COUNT), 1'b0, IS_SLV, IS_NET, IS_DDR}),
        .slip_en_o       (slip_en)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    reset_zero_a: assert property (disable iff (1'b0) sys_rst_i |=> par_out_bit_o == 6'h0)
        else $error("parallel outputs not cleared by reset");
    slip_bypass_a: assert property (!slip_ok |=> $stable(slip_cnt_reg))
        else $error("slip alignment moved while slip is off");
    slip_step_a: assert property (slip_step && int'(slip_cnt_reg) < CELL_W - 1
        |=> slip_cnt_reg == $past(slip_cnt_reg) + 4'h1)
        else $error("slip pulse did not advance alignment");
    mem_noslip_a: assert property (!IS_NET |-> slip_cnt_reg == 4'h0)
        else $error("slip active in memory model");
    strobe_ignore_a: assert property (IS_NET |-> strb_cnt_reg == 16'h0)
        else $error("strobe clock used in networking model");
    mem_latency_a: assert property (!IS_NET && slow_en
        |=> par_out_bit_o == 6'($past(raw_word) << OUT_LSB))
        else $error("memory model word not presented after one slow cycle");
    net_latency_a: assert property (IS_NET && slow_en && !slip_ok
        |=> stage_reg == $past(raw_word) ##0 par_out_bit_o == 6'(rotl($past(stage_reg), 0) << OUT_LSB))
        else $error("networking word not presented after two slow cycles");
    sdr_rise_a: assert property (!IS_DDR && fall[SY_FCLK] && !rise[SY_FCLK]
        |=> $stable(chain_reg))
        else $error("single rate sampled on a falling edge");
    ddr_both_a: assert property (IS_DDR && fall[SY_FCLK] && shift_en
        |=> chain_reg[5:1] == $past(chain_reg[4:0]))
        else $error("double rate missed a falling-edge sample");
    unused_low_a: assert property (CASC && IS_SLV |-> par_out_bit_o[1:0] == 2'h0)
        else $error("slave drove its low outputs");

    word_seen_c: cover property (slow_en ##1 par_out_bit_o != 6'h0);
    slip_seen_c: cover property (slip_step);
    two_slips_c: cover property (slip_step ##[1:64] slip_step);
    strobe_seen_c: cover property (rise[SY_STRB] && !IS_NET);
endmodule : ids_top

// File: verif/ids_tx_model.sv
// Source-synchronous serial transmitter model feeding the deserializer pins
`timescale 1ns/10ps
module ids_tx_model (
    output logic serial_o,
    output logic fast_clock_o,
    output logic slow_clock_o
);
    initial begin
        serial_o     = 1'h0;
        fast_clock_o = 1'h0;
        slow_clock_o = 1'h0;
    end
    // Earliest bit first; data changes mid-low so both fast edges see a settled level
    task automatic send(input logic [3:0] word);
        for (int i = 3; i >= 0; i--) begin
            serial_o = word[i];
            #16 fast_clock_o = 1'h1;
            #32 fast_clock_o = 1'h0;
            if (i == 0) slow_clock_o = 1'h1;
            if (i == 2) slow_clock_o = 1'h0;
            #16;
        end
        // Clocks stand still between frames; the idle line shows the inverse level
        serial_o = ~serial_o;
    endtask : send
endmodule : ids_tx_model

// File: verif/ids_top_bench.sv
// Self-checking bench of the deserializer: latency, ordering, slip, config and reset
`timescale 1ns/10ps
`include "ids_defs.svh"
module ids_top_bench;
    logic        mclk_i = 1'h0, sys_rst_i = 1'h1, slip = 1'h0, strb = 1'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rd;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    wire         ser, fclk, sclk, awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp, casc;
    wire  [5:0]  par;
    wire  [31:0] rdata;
    int          err_total = 0, n_checks = 0, cyc = 0;
    always #2.5 mclk_i = ~mclk_i;
    ids_tx_model tx (.serial_o(ser), .fast_clock_o(fclk), .slow_clock_o(sclk));
    ids_top #(.RATE_SEL(ids_pkg::IDS_SDR), .PAR_W(4), .USE_MODEL(ids_pkg::IDS_NETWORKING)) uut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .serial_i(ser), .fast_clock_i(fclk), .slow_clock_i(sclk),
        .strobe_clock_i(strb), .clock_enable_a_i(1'h1), .clock_enable_b_i(1'h1), .slip_pulse_i(slip),
        .cascade_in_i(2'h0), .cascade_out_o(casc), .par_out_bit_o(par),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    // Values read right after an edge are the ones the edge sampled
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        fork
            begin do @(posedge mclk_i); while (awready !== 1'h1); awvalid <= 1'h0; end
            begin do @(posedge mclk_i); while (wready !== 1'h1); wvalid <= 1'h0; end
        join
        do @(posedge mclk_i); while (bvalid !== 1'h1);
        chk(32'(bresp), 32'(`IDS_RESP_OKAY));
        bready <= 1'h0;
    endtask : axw
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        do @(posedge mclk_i); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge mclk_i);
        d = rdata;
        chk(32'(rresp), 32'(`IDS_RESP_OKAY));
        rready <= 1'h0;
    endtask : axr
    // Word lands four cycles after the slow edge: three sampler stages plus the output register
    task automatic word(input logic [3:0] w);
        tx.send(w);
        repeat (4) @(posedge mclk_i);
    endtask : word
    task automatic slip_word(input logic [3:0] w);
        @(posedge mclk_i) slip <= 1'h1;
        word(w);
        slip <= 1'h0;
    endtask : slip_word
    task automatic t_config();
        axr(`IDS_OFF_CTRL, rd);
        chk(rd, 32'h0);
        // No byte lane enabled: slip must stay off
        wstrb <= 4'h0;
        axw(`IDS_OFF_CTRL, 32'h1);
        wstrb <= 4'hF;
        axr(`IDS_OFF_CTRL, rd);
        chk(rd, 32'h0);
        axr(`IDS_OFF_CONFIG, rd);
        chk(rd, (32'h1 << `IDS_CFG_MODEL_LSB) | (32'h2 << `IDS_CFG_NCE_LSB) | (32'h4 << `IDS_CFG_WIDTH_LSB));
        // Strobe edges slow enough for the pin sampler; networking must not count them
        repeat (8) begin
            repeat (4) @(posedge mclk_i);
            strb <= ~strb;
        end
        repeat (4) @(posedge mclk_i);
        axr(`IDS_OFF_STROBE, rd);
        chk(rd, 32'h0);
        $display("config test done");
    endtask : t_config
    task automatic t_latency();
        word(4'hA);
        chk(32'(par), 32'h0);
        word(4'h5);
        chk(32'(par[3:0]), 32'hA);
        word(4'hC);
        chk(32'(par[3:0]), 32'h5);
        $display("latency test done");
    endtask : t_latency
    task automatic t_slip(input logic en, input logic [3:0] exp);
        axw(`IDS_OFF_CTRL, 32'(en));
        word(4'h9);
        slip_word(4'h9);
        repeat (3) word(4'h9);
        chk(32'(par[3:0]), 32'(exp));
        // Two bits older than the word: tail 0,1 of the previous 1001 frame
        chk(32'(casc), 32'h1);
        axr(`IDS_OFF_STATUS, rd);
        chk(rd & 32'hF0F, (32'(en) << `IDS_STAT_SLIP_LSB) | 32'(exp));
        $display("slip test done, enable=%0d", en);
    endtask : t_slip
    task automatic t_reset();
        @(posedge mclk_i) sys_rst_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        #1 chk(32'(par), 32'h0);
        @(posedge mclk_i) sys_rst_i <= 1'h0;
        axr(`IDS_OFF_CTRL, rd);
        chk(rd, 32'h0);
        $display("reset test done");
    endtask : t_reset
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        repeat (4) @(posedge mclk_i);
        t_config();
        t_latency();
        t_slip(1'h0, 4'h9);
        t_slip(1'h1, 4'h3);
        t_reset();
        results();
    end
endmodule : ids_top_bench
